// *** include/amtt_pkg.sv ***
// Package: offsets, fields, reset values and timing of the alert mask and timer slice
package amtt_pkg;
    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] AMTT_OFF_CHMASK = 8'h74;
    localparam logic [7:0] AMTT_OFF_FMASK = 8'h75;
    localparam logic [7:0] AMTT_OFF_VLOW = 8'h76;
    localparam logic [7:0] AMTT_OFF_TLOW = 8'h77;
    localparam logic [7:0] AMTT_OFF_CFG = 8'h78;
    localparam logic [7:0] AMTT_OFF_TMR = 8'h79;
    // ------------------------------------------------------------
    // Reset values and writable bits
    // ------------------------------------------------------------
    localparam logic [7:0] AMTT_RST_CHMASK = 8'h00;
    localparam logic [7:0] AMTT_RST_FMASK = 8'h00;
    localparam logic [7:0] AMTT_RST_CFG = 8'h00;
    localparam logic [7:0] AMTT_RST_TMR = 8'h00;
    localparam logic [7:0] AMTT_CHMASK_WR = 8'hF6;
    localparam logic [7:0] AMTT_CHMASK_SRC = 8'h76;
    localparam logic [7:0] AMTT_FMASK_WR = 8'hFC;
    localparam logic [7:0] AMTT_FMASK_SRC = 8'hFE;
    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int AMTT_CH_GATE = 7;
    localparam int AMTT_FM_OVT = 1;
    localparam int AMTT_CFG_ALERT = 0;
    localparam int AMTT_CFG_OTEN = 1;
    localparam int AMTT_CFG_BOOST = 2;
    localparam int AMTT_CFG_FAST = 3;
    localparam int AMTT_CFG_DC = 4;
    localparam int AMTT_LOW_A = 2;
    localparam int AMTT_LOW_B = 4;
    localparam int AMTT_LOW_C = 6;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int AMTT_CLK_MHZ = 50;
    localparam real AMTT_TMR_RES_MS = 22.76;
    localparam real AMTT_TMR_SHOW_MS = 45.52;
    localparam int AMTT_TICK_CYC = int'(AMTT_TMR_RES_MS * 1000.0 * AMTT_CLK_MHZ);
    localparam logic [7:0] AMTT_SHOW_TICKS = 8'(int'(AMTT_TMR_SHOW_MS / AMTT_TMR_RES_MS));
endpackage

// *** rtl/amtt_regs.sv ***
// Alert masks, low-bit readings, pin/tach configuration and overheat timer registers
`timescale 1ns/1ps
// Behaviour
// - Channel mask bits 1 and 2 block alerts of core and supply voltage channels.
// - Channel mask bits 4, 5, 6 block alerts of remote one, local, remote two.
// - Channel mask bit 7 clear lets any second-status alert through regardless of masks.
// - Fault mask bit 1 is read-only and blocks overheat signal alerts.
// - Fault mask bits 2, 3, 4 block fan one, two, three fault alerts.
// - Fault mask bit 5 blocks fan four fault, or timer event in thermal mode.
// - Fault mask bits 6 and 7 block diode faults on remote one and two.
// - Voltage low-bits register returns core bits 3:2 and supply bits 5:4.
// - Temperature low-bits register returns remote one, local, remote two low bits.
// - Reading a low-bits register freezes it and high bytes until high bytes read.
// - Config bit 0 turns the shared fan-drive pin into the alert output.
// - Config bit 1 with pin function enables overheat signal; direction set elsewhere.
// - Overheat input asserted with boost bit drives fans to maximum duty.
// - Config bit 3 raises tach rate from once a second to every 250 ms.
// - Config bits 4 to 7 make tach continuous, no pulse stretch, per fan.
// - With the lock bit set, config register writes are ignored.
// - Timer bits 7:1 count assertion time, read zero until 45.52 ms is reached.
// - Timer bit 0 set on assertion, cleared on read, later becomes count LSB.
// - Count resolution is 22.76 ms, covering 45.52 ms to 5.80 seconds.
// - Assertion beyond timer limit raises the timer event; zero limit raises immediately.
// - Power-down bit turns all fans off and duty readings read zero.
module amtt_regs
    import amtt_pkg::*;
#(
    parameter int TICK_CYCLES = AMTT_TICK_CYC
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Register port
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    // Status and control from the rest of the device
    input wire logic [7:0] channel_status,
    input wire logic [7:0] fault_status,
    input wire logic lock_bit,
    input wire logic overheat_event_mask,
    input wire logic shared_pin_function,
    input wire logic overtemp_is_input,
    input wire logic power_down_bit,
    input wire logic [7:0] timer_limit,
    // Measurement low bits and high-byte read strobes
    input wire logic [1:0] core_voltage_channel_low,
    input wire logic [1:0] supply_low_bits,
    input wire logic [1:0] remote_one_low_bits,
    input wire logic [1:0] local_low_bits,
    input wire logic [1:0] remote_two_low_bits,
    input wire logic volt_high_read,
    input wire logic temp_high_read,
    output logic volt_frozen,
    output logic temp_frozen,
    // Overheat signal pin, active low
    input wire logic overtemp_signal_n,
    // Alert pin, open drain
    output logic smbalert_o,
    output logic smbalert_oe,
    output logic alert_pin_select,
    // Fan and tach control
    output logic overtemp_enable,
    output logic fans_full,
    output logic fast_tach,
    output logic [3:0] continuous_tach,
    output logic fans_off,
    output logic duty_read_zero,
    output logic timer_event
);
    localparam int TW = $clog2(TICK_CYCLES + 1);
    localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYCLES - 1);

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [7:0] chm_q, chm_d, fm_q, fm_d, cfg_q, cfg_d;
    logic [7:0] vl_q, vl_d, tl_q, tl_d, rdata_q, rdata_d;
    logic fzv_q, fzv_d, fzt_q, fzt_d;
    logic s1_q, s2_q, s3_q;
    logic [TW-1:0] tick_q, tick_d;
    logic [7:0] dur_q, dur_d;
    logic seen_q, seen_d, evt_q, evt_d, alert_q, alert_d, full_q, full_d;
    logic asrt, rise, tick, rd_vl, rd_tl, rd_tmr;
    logic [7:0] fm_view, tmr_view;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        return a == off;
    endfunction

    assign asrt = s2_q;
    assign rise = s2_q & ~s3_q;
    assign tick = asrt && tick_q == TICK_LAST;
    assign rd_vl = reg_rd && hit(reg_addr, AMTT_OFF_VLOW);
    assign rd_tl = reg_rd && hit(reg_addr, AMTT_OFF_TLOW);
    assign rd_tmr = reg_rd && hit(reg_addr, AMTT_OFF_TMR);
    assign fm_view = {fm_q[7:2], overheat_event_mask, 1'b0};
    // Below the display threshold only the seen flag shows
    assign tmr_view = (dur_q >= AMTT_SHOW_TICKS) ? dur_q : {7'h00, seen_q};

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb begin
        chm_d = chm_q;
        fm_d = fm_q;
        cfg_d = cfg_q;
        rdata_d = rdata_q;
        if (reg_wr) begin
            case (reg_addr)
                AMTT_OFF_CHMASK: chm_d = reg_wdata & AMTT_CHMASK_WR;
                AMTT_OFF_FMASK: fm_d = reg_wdata & AMTT_FMASK_WR;
                AMTT_OFF_CFG: begin
                    if (!lock_bit) begin
                        cfg_d = reg_wdata;
                    end
                end
                default: begin
                end
            endcase
        end
        if (reg_rd) begin
            case (reg_addr)
                AMTT_OFF_CHMASK: rdata_d = chm_q;
                AMTT_OFF_FMASK: rdata_d = fm_view;
                AMTT_OFF_VLOW: rdata_d = vl_q;
                AMTT_OFF_TLOW: rdata_d = tl_q;
                AMTT_OFF_CFG: rdata_d = cfg_q;
                AMTT_OFF_TMR: rdata_d = tmr_view;
                default: rdata_d = 8'h00;
            endcase
        end
        // Freeze on low-bits read, release on high-byte read; set wins
        fzv_d = rd_vl | (fzv_q & ~volt_high_read);
        fzt_d = rd_tl | (fzt_q & ~temp_high_read);
        vl_d = vl_q;
        tl_d = tl_q;
        if (!fzv_q && !rd_vl) begin
            vl_d = 8'h00;
            vl_d[AMTT_LOW_A +: 2] = core_voltage_channel_low;
            vl_d[AMTT_LOW_B +: 2] = supply_low_bits;
        end
        if (!fzt_q && !rd_tl) begin
            tl_d[AMTT_LOW_A +: 2] = remote_one_low_bits;
            tl_d[AMTT_LOW_B +: 2] = local_low_bits;
            tl_d[AMTT_LOW_C +: 2] = remote_two_low_bits;
            tl_d[1:0] = 2'b00;
        end
        // Overheat duration timer
        tick_d = (!asrt || tick) ? '0 : tick_q + TW'(1);
        dur_d = dur_q;
        if (rise) begin
            dur_d = 8'h00;
        end else if (tick && dur_q != 8'hFF) begin
            dur_d = dur_q + 8'h01;
        end
        seen_d = rise | (seen_q & ~rd_tmr);
        evt_d = (rise && timer_limit == 8'h00)
              || (tick && timer_limit != 8'h00 && dur_q == timer_limit);
        // Alert combine
        alert_d = (|(channel_status & ~chm_q & AMTT_CHMASK_SRC))
               || (|(fault_status & ~fm_view & AMTT_FMASK_SRC))
               || (!chm_q[AMTT_CH_GATE] && |fault_status);
        full_d = cfg_q[AMTT_CFG_OTEN] && shared_pin_function && overtemp_is_input
              && cfg_q[AMTT_CFG_BOOST] && asrt;
    end

    // ------------------------------------------------------------
    // State registers
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            chm_q <= AMTT_RST_CHMASK;
            fm_q <= AMTT_RST_FMASK;
            cfg_q <= AMTT_RST_CFG;
            vl_q <= 8'h00;
            tl_q <= 8'h00;
            rdata_q <= 8'h00;
            fzv_q <= 1'b0;
            fzt_q <= 1'b0;
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
            tick_q <= '0;
            dur_q <= AMTT_RST_TMR;
            seen_q <= 1'b0;
            evt_q <= 1'b0;
            alert_q <= 1'b0;
            full_q <= 1'b0;
        end else begin
            chm_q <= chm_d;
            fm_q <= fm_d;
            cfg_q <= cfg_d;
            vl_q <= vl_d;
            tl_q <= tl_d;
            rdata_q <= rdata_d;
            fzv_q <= fzv_d;
            fzt_q <= fzt_d;
            s1_q <= ~overtemp_signal_n;
            s2_q <= s1_q;
            s3_q <= s2_q;
            tick_q <= tick_d;
            dur_q <= dur_d;
            seen_q <= seen_d;
            evt_q <= evt_d;
            alert_q <= alert_d;
            full_q <= full_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign reg_rdata = rdata_q;
    assign volt_frozen = fzv_q;
    assign temp_frozen = fzt_q;
    assign smbalert_o = 1'b0;
    assign smbalert_oe = alert_q & cfg_q[AMTT_CFG_ALERT];
    assign alert_pin_select = cfg_q[AMTT_CFG_ALERT];
    assign overtemp_enable = cfg_q[AMTT_CFG_OTEN] & shared_pin_function;
    assign fans_full = full_q;
    assign fast_tach = cfg_q[AMTT_CFG_FAST];
    assign continuous_tach = cfg_q[AMTT_CFG_DC +: 4];
    assign fans_off = power_down_bit;
    assign duty_read_zero = power_down_bit;
    assign timer_event = evt_q;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    AST_CH_MASK: assert property (fault_status == 8'h00 && (channel_status & ~8'h06) == 8'h00
        && (channel_status & 8'h06 & ~chm_q) == 8'h00 |=> !alert_q)
        else $error("masked voltage channels raised alert");
    AST_TEMP_MASK: assert property (fault_status == 8'h00 && channel_status[4]
        && !chm_q[4] |=> alert_q)
        else $error("unmasked remote one channel gave no alert");
    AST_GATE: assert property (!chm_q[AMTT_CH_GATE] && |fault_status |=> alert_q)
        else $error("second status alert lost with gate clear");
    AST_FMASK: assert property (chm_q[AMTT_CH_GATE] && channel_status == 8'h00
        && (fault_status & ~fm_view & AMTT_FMASK_SRC) == 8'h00 |=> !alert_q)
        else $error("fully masked faults raised alert");
    AST_RDONLY: assert property (reg_wr && reg_addr == AMTT_OFF_FMASK
        |=> fm_q[1:0] == 2'b00)
        else $error("read-only fault mask bit stored");
    AST_FREEZE: assert property (rd_vl ##1 !volt_high_read [*2] |-> $stable(vl_q))
        else $error("voltage low bits changed while frozen");
    AST_LOCK: assert property (reg_wr && reg_addr == AMTT_OFF_CFG && lock_bit
        |=> $stable(cfg_q))
        else $error("locked config register changed");
    AST_SEEN: assert property (rise |=> seen_q && dur_q == 8'h00)
        else $error("assertion not flagged");
    AST_HIDE: assert property (dur_q < AMTT_SHOW_TICKS |-> tmr_view[7:1] == 7'h00)
        else $error("count shown below threshold");
    AST_ZERO_LIM: assert property (rise && timer_limit == 8'h00 |=> timer_event)
        else $error("zero limit gave no immediate event");
    AST_BOOST: assert property (asrt && cfg_q[2:1] == 2'b11 && shared_pin_function
        && overtemp_is_input |=> fans_full)
        else $error("boost did not run fans full");

    COV_ALERT: cover property (rise ##1 smbalert_oe);
    COV_FREEZE: cover property (rd_vl ##[1:20] volt_high_read);
    COV_TIMER: cover property (tick && dur_q == 8'h02);
endmodule

// *** tb/alert_mask_overtemp_signal_timer_regs_bench.sv ***
// Self-checking bench for the alert mask and overheat timer registers
`timescale 1ns/1ps
module alert_mask_overtemp_signal_timer_regs_bench;
    import amtt_pkg::*;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic reg_wr, reg_rd, alert_n;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, v;
    logic [7:0] chs = 8'h00, fts = 8'h00, lim = 8'h00;
    logic lock = 1'b0, ovm = 1'b0, spf = 1'b1, oin = 1'b1, pdn = 1'b0;
    logic [9:0] lows = 10'h000;
    logic vhr = 1'b0, thr = 1'b0, ot_n = 1'b1;
    logic vfz, tfz, sa_o, sa_oe, aps, ote, ffull, ftach, foff, dzero, tev;
    logic [3:0] ctach;
    int failures = 0, num_checks = 0, events = 0;
    int bits[5] = '{1, 2, 4, 5, 6};
    initial forever #10 core_clk = ~core_clk;
    always @(posedge core_clk) if (tev === 1'b1) events++;
    amtt_regs #(.TICK_CYCLES(20)) u_amtt_regs (.core_clk(core_clk), .rst_n(rst_n),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .channel_status(chs), .fault_status(fts), .lock_bit(lock),
        .overheat_event_mask(ovm), .shared_pin_function(spf), .overtemp_is_input(oin),
        .power_down_bit(pdn), .timer_limit(lim), .core_voltage_channel_low(lows[1:0]),
        .supply_low_bits(lows[3:2]), .remote_one_low_bits(lows[5:4]),
        .local_low_bits(lows[7:6]), .remote_two_low_bits(lows[9:8]),
        .volt_high_read(vhr), .temp_high_read(thr), .volt_frozen(vfz), .temp_frozen(tfz),
        .overtemp_signal_n(ot_n), .smbalert_o(sa_o), .smbalert_oe(sa_oe),
        .alert_pin_select(aps), .overtemp_enable(ote), .fans_full(ffull),
        .fast_tach(ftach), .continuous_tach(ctach), .fans_off(foff),
        .duty_read_zero(dzero), .timer_event(tev));
    amtt_host u_amtt_host (.core_clk(core_clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .smbalert_o(sa_o), .smbalert_oe(sa_oe), .alert_n(alert_n));
    // ------------------------------------------------------------
    // Checking tasks
    // ------------------------------------------------------------
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("FAIL %0t: got %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        u_amtt_host.rd(a, d);
        check(d, exp);
    endtask
    task automatic alert_case(input logic [7:0] c, f, cm, fm, input logic exp);
        u_amtt_host.wr(AMTT_OFF_CHMASK, cm);
        u_amtt_host.wr(AMTT_OFF_FMASK, fm);
        #1 chs = c;
        fts = f;
        repeat (3) @(posedge core_clk);
        #1 check({7'h00, alert_n}, {7'h00, !exp});
        chs = 8'h00;
        fts = 8'h00;
        repeat (3) @(posedge core_clk);
    endtask
    task automatic tally_and_finish();
        $display("Checks %0d, mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    initial begin
        #200000;
        failures++;
        tally_and_finish();
    end
    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial begin
        repeat (2) @(posedge core_clk);
        #1 rst_n = 1'b1;
        rdchk(AMTT_OFF_FMASK, 8'h00);
        rdchk(AMTT_OFF_CFG, 8'h00);
        rdchk(AMTT_OFF_TMR, 8'h00);
        rdchk(8'h80, 8'h00);
        u_amtt_host.wr(AMTT_OFF_CHMASK, 8'hFF);
        rdchk(AMTT_OFF_CHMASK, 8'hF6);
        u_amtt_host.wr(AMTT_OFF_FMASK, 8'hFF);
        rdchk(AMTT_OFF_FMASK, 8'hFC);
        ovm = 1'b1;
        rdchk(AMTT_OFF_FMASK, 8'hFE);
        ovm = 1'b0;
        u_amtt_host.wr(AMTT_OFF_CFG, 8'hFF);
        rdchk(AMTT_OFF_CFG, 8'hFF);
        check({aps, ftach, ctach, ote, 1'b0}, 8'hFE);
        lock = 1'b1;
        u_amtt_host.wr(AMTT_OFF_CFG, 8'h00);
        rdchk(AMTT_OFF_CFG, 8'hFF);
        lock = 1'b0;
        u_amtt_host.wr(AMTT_OFF_CFG, 8'h00);
        alert_case(8'h02, 8'h00, 8'h00, 8'h00, 1'b0);
        u_amtt_host.wr(AMTT_OFF_CFG, 8'h01);
        foreach (bits[i]) begin
            alert_case(8'h01 << bits[i], 8'h00, 8'h00, 8'h00, 1'b1);
            alert_case(8'h01 << bits[i], 8'h00, 8'h01 << bits[i], 8'h00, 1'b0);
        end
        for (int b = 2; b < 8; b++) begin
            alert_case(8'h00, 8'h01 << b, 8'h80, 8'h00, 1'b1);
            alert_case(8'h00, 8'h01 << b, 8'h80, 8'h01 << b, 1'b0);
        end
        alert_case(8'h00, 8'h02, 8'h80, 8'h00, 1'b1);
        ovm = 1'b1;
        alert_case(8'h00, 8'h02, 8'h80, 8'h00, 1'b0);
        alert_case(8'h00, 8'h10, 8'h00, 8'hFC, 1'b1);
        ovm = 1'b0;
        lows = 10'b10_01_11_10_01;
        rdchk(AMTT_OFF_VLOW, 8'h24);
        rdchk(AMTT_OFF_TLOW, 8'h9C);
        lows = ~lows;
        rdchk(AMTT_OFF_VLOW, 8'h24);
        rdchk(AMTT_OFF_TLOW, 8'h9C);
        check({6'h00, vfz, tfz}, 8'h03);
        @(posedge core_clk);
        #1 vhr = 1'b1;
        thr = 1'b1;
        @(posedge core_clk);
        #1 vhr = 1'b0;
        thr = 1'b0;
        check({6'h00, vfz, tfz}, 8'h00);
        rdchk(AMTT_OFF_VLOW, 8'h18);
        rdchk(AMTT_OFF_TLOW, 8'h60);
        pdn = 1'b1;
        #1 check({6'h00, foff, dzero}, 8'h03);
        pdn = 1'b0;
        u_amtt_host.wr(AMTT_OFF_CFG, 8'h07);
        lim = 8'h02;
        ot_n = 1'b0;
        repeat (5) @(posedge core_clk);
        rdchk(AMTT_OFF_TMR, 8'h01);
        rdchk(AMTT_OFF_TMR, 8'h00);
        check({7'h00, ffull}, 8'h01);
        repeat (60) @(posedge core_clk);
        rdchk(AMTT_OFF_TMR, 8'h03);
        check(8'(events), 8'h01);
        #1 ot_n = 1'b1;
        repeat (10) @(posedge core_clk);
        #1 lim = 8'h00;
        ot_n = 1'b0;
        repeat (10) @(posedge core_clk);
        check(8'(events), 8'h02);
        rdchk(AMTT_OFF_TMR, 8'h01);
        ot_n = 1'b1;
        tally_and_finish();
    end
endmodule

// *** tb/amtt_host.sv ***
// Host model: register strobe driver and pulled-up alert wire
`timescale 1ns/1ps
module amtt_host (
    // Clock
    input wire logic core_clk,
    // Register port
    output logic reg_wr,
    output logic reg_rd,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    // Alert pin
    input wire logic smbalert_o,
    input wire logic smbalert_oe,
    output logic alert_n
);
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
    end
    // Pull-up wins when nobody drives the pin
    assign alert_n = smbalert_oe ? smbalert_o : 1'b1;
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        #1 reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(posedge core_clk);
        #1 reg_wr = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask
    // Low-bit registers are read before their high bytes
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge core_clk);
        #1 reg_rd = 1'b1;
        reg_addr = a;
        @(posedge core_clk);
        #1 reg_rd = 1'b0;
        reg_addr = ~a;
        d = reg_rdata;
    endtask
endmodule
